//--- rtl/seql_regs.vh
`ifndef SEQL_REGS_VH
`define SEQL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SEQL_ADDR_ORDER_CH2 8'h81
`define SEQL_ADDR_ORDER_CH3 8'h82
`define SEQL_ADDR_ORDER_CH4 8'h83
`define SEQL_ADDR_ORDER_CH5 8'h84
`define SEQL_ADDR_ORDER_CH6 8'h85
`define SEQL_ADDR_TS_HIGH_CH1 8'h90
`define SEQL_ADDR_TS_LOW_CH1 8'h91

// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define SEQL_FIELD_MSB 7
`define SEQL_FIELD_LSB 0
`define SEQL_RESET_VAL 8'h00
`define SEQL_UNMAPPED_VAL 8'h00

// ----------------------------------------------------------------
// Control codes: two-bit history of a control, old value first
// ----------------------------------------------------------------
`define SEQL_CTRL_RISE 2'h1
`define SEQL_CTRL_FALL 2'h2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SEQL_CLK_PERIOD_PS 5000
`define SEQL_TIMER_STEP_US 50
`define SEQL_TIMER_STEP_CYC ((`SEQL_TIMER_STEP_US * 1000000) / `SEQL_CLK_PERIOD_PS)

`endif

//--- rtl/seql_sync.v
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Three-stage synchroniser with agreement of stages two and three
// ----------------------------------------------------------------
module seql_sync #(
    parameter WIDTH = 1
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;
    integer i;

    // A bit only changes once both later stages show the new level.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_r <= {WIDTH{1'b0}};
            stage2_r <= {WIDTH{1'b0}};
            stage3_r <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_r[i] == stage3_r[i]) begin
                    syncOut[i] <= stage3_r[i];
                end
            end
        end
    end

endmodule // seql_sync

//--- rtl/seql_sequence_order_time_log.v
// Function
// - Tag channels on sleep-entry off-threshold crossing.
// - Tag equals shared order counter at crossing.
// - Order logs ch2-6 at 0x81 onward, RO.
// - Channel 1 timestamp high byte at 0x90.
// - Power-on/sleep-exit: store on rising undervoltage crossing.
// - Power-off/sleep-entry: store on falling off crossing.
// - Sequence timer advances every 50 us.
// - Channel 1 timestamp low byte at 0x91.
`timescale 1ns/100ps
`include "seql_regs.vh"

module seql_sequence_order_time_log #(
    parameter NUM_ORDER_CH = 5,
    parameter TIMER_WIDTH = 16,
    parameter STEP_CYCLES = `SEQL_TIMER_STEP_CYC
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [1:0] activeControl,
    input wire [1:0] sleepControl,
    input wire [5:0] offCompBelow,
    input wire lowFreqUvAbove,
    input wire [7:0] sharedOrderCounter,
    input wire [7:0] regAddr,
    input wire regRead,
    output reg [7:0] regRdata,
    output wire [TIMER_WIDTH-1:0] sequenceTimer
);

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    // Controls, comparators and the UV level come from analog or pin
    // domains; the shared counter is assumed to be on sys_clk already.
    wire [10:0] syncBus;
    seql_sync #(
        .WIDTH(11)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .asyncIn({lowFreqUvAbove, offCompBelow, activeControl, sleepControl}),
        .syncOut(syncBus)
    );

    wire [1:0] sleepSync = syncBus[1:0];
    wire [1:0] activeSync = syncBus[3:2];
    wire [5:0] offSync = syncBus[9:4];
    wire uvSync = syncBus[10];

    // ----------------------------------------------------------------
    // Sequence tracking
    // ----------------------------------------------------------------
    // Each control is a two-bit history; 01 is a rise, 10 a fall.
    reg [1:0] sleepPrev_r;
    reg [1:0] activePrev_r;
    reg [5:0] offPrev_r;
    reg uvPrev_r;
    reg sleepEntry_r;
    reg activeOff_r;
    reg riseSeq_r;

    // A start counts only on the first cycle its code shows, so a control
    // parked on 01 or 10 does not restart the timer on every cycle.
    function seqStart;
        input [1:0] cur;
        input [1:0] prev;
        input [1:0] code;
        begin
            seqStart = (cur == code) && (prev != code);
        end
    endfunction

    wire sleepEntryStart = seqStart(sleepSync, sleepPrev_r, `SEQL_CTRL_FALL);
    wire sleepExitStart = seqStart(sleepSync, sleepPrev_r, `SEQL_CTRL_RISE);
    wire activeOffStart = seqStart(activeSync, activePrev_r, `SEQL_CTRL_FALL);
    wire activeOnStart = seqStart(activeSync, activePrev_r, `SEQL_CTRL_RISE);
    wire anyStart = sleepEntryStart | sleepExitStart | activeOffStart | activeOnStart;

    wire [5:0] offCross = offSync & ~offPrev_r;
    wire uvCross = uvSync & ~uvPrev_r;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sleepPrev_r <= 2'h0;
            activePrev_r <= 2'h0;
            offPrev_r <= 6'h00;
            uvPrev_r <= 1'b0;
            sleepEntry_r <= 1'b0;
            activeOff_r <= 1'b0;
            riseSeq_r <= 1'b0;
        end else begin
            sleepPrev_r <= sleepSync;
            activePrev_r <= activeSync;
            offPrev_r <= offSync;
            uvPrev_r <= uvSync;
            if (anyStart) begin
                sleepEntry_r <= sleepEntryStart;
                activeOff_r <= activeOffStart;
                riseSeq_r <= sleepExitStart | activeOnStart;
            end
        end
    end

    // ----------------------------------------------------------------
    // Sequence timer
    // ----------------------------------------------------------------
    reg [15:0] stepCnt_r;
    reg [15:0] stepCnt_nxt;
    reg [TIMER_WIDTH-1:0] seqTimer_r;
    reg [TIMER_WIDTH-1:0] seqTimer_nxt;
    assign sequenceTimer = seqTimer_r;

    // 50 us step
    // The step counter restarts with the sequence, so the first count lands
    // one full step after the start rather than somewhere inside a step.
    always @* begin
        stepCnt_nxt = stepCnt_r + 16'h0001;
        seqTimer_nxt = seqTimer_r;
        if (anyStart) begin
            stepCnt_nxt = 16'h0000;
            seqTimer_nxt = {TIMER_WIDTH{1'b0}};
        end else if (stepCnt_r == STEP_CYCLES[15:0] - 16'h0001) begin
            stepCnt_nxt = 16'h0000;
            seqTimer_nxt = seqTimer_r + {{(TIMER_WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stepCnt_r <= 16'h0000;
            seqTimer_r <= {TIMER_WIDTH{1'b0}};
        end else begin
            stepCnt_r <= stepCnt_nxt;
            seqTimer_r <= seqTimer_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Capture registers
    // ----------------------------------------------------------------
    reg [7:0] orderLog_r [0:NUM_ORDER_CH-1];
    reg [TIMER_WIDTH-1:0] timestamp_r;
    integer ch;
    reg [TIMER_WIDTH-1:0] timestamp_nxt;
    wire fallCapture = (sleepEntry_r || activeOff_r) && offCross[0];
    wire riseCapture = riseSeq_r && uvCross;

    // One timestamp serves every sequence type, so the latest crossing wins.
    // A user who needs both edges must read the value between sequences.
    always @* begin
        timestamp_nxt = timestamp_r;
        if (fallCapture) begin
            timestamp_nxt = seqTimer_r;
        end else if (riseCapture) begin
            timestamp_nxt = seqTimer_r;
        end
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (ch = 0; ch < NUM_ORDER_CH; ch = ch + 1) begin
                orderLog_r[ch] <= `SEQL_RESET_VAL;
            end
            timestamp_r <= {TIMER_WIDTH{1'b0}};
        end else begin
            for (ch = 0; ch < NUM_ORDER_CH; ch = ch + 1) begin
                if (sleepEntry_r && offCross[ch+1]) begin
                    orderLog_r[ch] <= sharedOrderCounter;
                end
            end
            timestamp_r <= timestamp_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Register read port
    // ----------------------------------------------------------------
    // Reads only steer the mux, so repeated reads never disturb a log.
    // The two timestamp bytes are not latched as a pair; read them while no
    // sequence is running or the halves may come from different captures.
    reg [7:0] regRdata_nxt;

    always @* begin
        regRdata_nxt = regRdata;
        if (regRead) begin
            case (regAddr)
                `SEQL_ADDR_ORDER_CH2: regRdata_nxt = orderLog_r[0];
                `SEQL_ADDR_ORDER_CH3: regRdata_nxt = orderLog_r[1];
                `SEQL_ADDR_ORDER_CH4: regRdata_nxt = orderLog_r[2];
                `SEQL_ADDR_ORDER_CH5: regRdata_nxt = orderLog_r[3];
                `SEQL_ADDR_ORDER_CH6: regRdata_nxt = orderLog_r[4];
                `SEQL_ADDR_TS_HIGH_CH1: regRdata_nxt = timestamp_r[15:8];
                `SEQL_ADDR_TS_LOW_CH1: regRdata_nxt = timestamp_r[7:0];
                default: regRdata_nxt = `SEQL_UNMAPPED_VAL;
            endcase
        end
    end

    // Unmapped addresses read as zero so host code can probe the map safely.
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= `SEQL_RESET_VAL;
        end else begin
            regRdata <= regRdata_nxt;
        end
    end

endmodule // seql_sequence_order_time_log

//--- tb/seql_host_model.sv
`timescale 1ns/100ps
// ----
// Host register reader
// ----
module seql_host_model (
    input wire sys_clk,
    input wire [7:0] regRdata,
    output reg [7:0] regAddr,
    output reg regRead
);
    initial begin
        regAddr = 8'h00;
        regRead = 1'b0;
    end
    task rd(input [7:0] a, output [7:0] d);
        @(negedge sys_clk);
        regAddr = a;
        regRead = 1'b1;
        @(negedge sys_clk);
        regRead = 1'b0;
        // The address is turned over so a stale decode cannot pass.
        regAddr = ~a;
        @(negedge sys_clk);
        d = regRdata;
    endtask
endmodule // seql_host_model

//--- tb/seql_sequence_order_time_log_asserts.sv
`timescale 1ns/100ps
`include "seql_regs.vh"
// ----
// Read port and timer checks
// ----
module seql_checker #(
    parameter STEP_CYCLES = 4
) (
    input wire sys_clk,
    input wire rst_b,
    input wire [1:0] activeControl,
    input wire [1:0] sleepControl,
    input wire [7:0] regAddr,
    input wire regRead,
    input wire [7:0] regRdata,
    input wire [15:0] sequenceTimer
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire mapped = (regAddr >= 8'h81 && regAddr <= 8'h85) || regAddr == 8'h90 || regAddr == 8'h91;
    sequence seqBump;
        $changed(sequenceTimer) && sequenceTimer != 16'h0000;
    endsequence
    property pClear(logic [1:0] c, logic [1:0] code);
        $changed(c) && c == code |-> ##[2:6] sequenceTimer == 16'h0000;
    endproperty
    AST_READ_HOLD: assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (regRead && !mapped |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    AST_RESET_ZERO: assert property ($rose(rst_b) |-> regRdata == 8'h00 && sequenceTimer == 16'h0000)
        else $error("outputs not cleared by reset");
    AST_TIMER_STEP: assert property ($changed(sequenceTimer) |->
        sequenceTimer == $past(sequenceTimer) + 16'h0001 || sequenceTimer == 16'h0000)
        else $error("timer jumped");
    AST_TIMER_HOLD: assert property (seqBump |=>
        (sequenceTimer == $past(sequenceTimer) || sequenceTimer == 16'h0000) [*3])
        else $error("timer step too short");
    AST_PON_CLEAR: assert property (pClear(activeControl, `SEQL_CTRL_RISE))
        else $error("power-on start missed");
    AST_POFF_CLEAR: assert property (pClear(activeControl, `SEQL_CTRL_FALL))
        else $error("power-off start missed");
    AST_SEXIT_CLEAR: assert property (pClear(sleepControl, `SEQL_CTRL_RISE))
        else $error("sleep-exit start missed");
    AST_SENTRY_CLEAR: assert property (pClear(sleepControl, `SEQL_CTRL_FALL))
        else $error("sleep-entry start missed");
endmodule // seql_checker
bind seql_sequence_order_time_log seql_checker #(.STEP_CYCLES(STEP_CYCLES)) seql_checker_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .activeControl(activeControl), .sleepControl(sleepControl),
    .regAddr(regAddr), .regRead(regRead), .regRdata(regRdata), .sequenceTimer(sequenceTimer));

//--- tb/testbench.sv
`timescale 1ns/100ps
// ----
// Log register bench
// ----
module testbench;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [1:0] activeCtl = 2'h0;
    reg [1:0] slpCtl = 2'h0;
    reg [5:0] offBelow = 6'h00;
    reg uvAbove = 1'b0;
    reg [7:0] ordCnt = 8'h00;
    wire [7:0] regAddr;
    wire regRead;
    wire [7:0] regRdata;
    wire [15:0] tmr;
    integer errorCnt = 0;
    integer samplesChecked = 0;
    integer cyc = 0;
    integer i;
    reg [7:0] d;
    initial forever #2.5 sys_clk = ~sys_clk;
    seql_sequence_order_time_log #(.STEP_CYCLES(4)) seql_sequence_order_time_log_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .activeControl(activeCtl), .sleepControl(slpCtl), .offCompBelow(offBelow),
        .lowFreqUvAbove(uvAbove), .sharedOrderCounter(ordCnt), .regAddr(regAddr), .regRead(regRead),
        .regRdata(regRdata), .sequenceTimer(tmr));
    seql_host_model seql_host_model_inst (.sys_clk(sys_clk), .regRdata(regRdata), .regAddr(regAddr),
        .regRead(regRead));
    task chk(input [7:0] a, input [7:0] e);
        seql_host_model_inst.rd(a, d);
        samplesChecked = samplesChecked + 1;
        if (d !== e) begin
            errorCnt = errorCnt + 1;
            $display("wrong value at %0t: got %h expected %h", $time, d, e);
        end
    endtask
    task testDone;
        $display("errors %0d checks %0d", errorCnt, samplesChecked);
        if (errorCnt == 0 && samplesChecked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task resetReads;
        for (i = 0; i < 5; i = i + 1) chk(8'h81 + i[7:0], 8'h00);
        chk(8'h90, 8'h00);
        chk(8'h80, 8'h00);
        chk(8'hFF, 8'h00);
    endtask
    // Channels fall in reverse order so an arrival-order slot mapping is exposed.
    task orderCase;
        slpCtl = 2'h2;
        repeat (8) @(negedge sys_clk);
        for (i = 4; i >= 0; i = i - 1) begin
            ordCnt = 8'hA0 + i[7:0];
            offBelow[i + 1] = 1'b1;
            repeat (8) @(negedge sys_clk);
        end
        activeCtl = 2'h1;
        offBelow[1] = 1'b0;
        repeat (8) @(negedge sys_clk);
        ordCnt = 8'h55;
        offBelow[1] = 1'b1;
        repeat (8) @(negedge sys_clk);
        for (i = 0; i < 10; i = i + 1) chk(8'h81 + i[7:0] % 5, 8'hA0 + i[7:0] % 5);
    endtask
    // The crossing lands mid-step, so a one-cycle sync skew cannot change the count.
    task tsCase(input [1:0] a, input [1:0] s, input [15:0] k);
        activeCtl = 2'h0;
        slpCtl = 2'h0;
        offBelow[0] = 1'b0;
        uvAbove = 1'b0;
        repeat (8) @(negedge sys_clk);
        activeCtl = a;
        slpCtl = s;
        repeat (4 * k + 2) @(negedge sys_clk);
        if (a == 2'h1 || s == 2'h1)
            uvAbove = 1'b1;
        else
            offBelow[0] = 1'b1;
        repeat (8) @(negedge sys_clk);
        chk(8'h90, k[15:8]);
        chk(8'h91, k[7:0]);
    endtask
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            errorCnt = errorCnt + 1;
            testDone;
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        resetReads;
        orderCase;
        tsCase(2'h1, 2'h0, 16'h0123);
        tsCase(2'h2, 2'h0, 16'h0045);
        tsCase(2'h0, 2'h1, 16'h0201);
        tsCase(2'h0, 2'h2, 16'h00AB);
        testDone;
    end
endmodule // testbench
